// ===== hdl/prdc_params.svh
`ifndef PRDC_PARAMS_SVH
`define PRDC_PARAMS_SVH
// Register byte offsets
`define PRDC_OFF_SYNTH     8'h00
`define PRDC_OFF_REF       8'h04
`define PRDC_OFF_IRQ_STAT  8'h08
`define PRDC_OFF_IRQ_MASK  8'h0C
// Synthesizer word fields
`define PRDC_MUX_HI        31
`define PRDC_MUX_LO        29
`define PRDC_INT_HI        26
`define PRDC_INT_LO        19
`define PRDC_FRAC_HI       18
`define PRDC_FRAC_LO       4
// Reference word fields
`define PRDC_HALVER_BIT    18
`define PRDC_BIAS_HI       14
`define PRDC_BIAS_LO       13
`define PRDC_OSC_BIT       12
`define PRDC_CKDIV_HI      10
`define PRDC_CKDIV_LO      7
`define PRDC_RDIV_HI       6
`define PRDC_RDIV_LO       4
// Reset values: oscillator on, output divide 8 (field 4), R = 1
`define PRDC_SYNTH_RST     32'h0000_0000
`define PRDC_REF_RST       32'h0000_1210
// Divider limits
`define PRDC_INT_MIN       8'h17
// Lock detect thresholds in ns and cycle count
`define PRDC_LOCK_IN_NS    8'h0F
`define PRDC_LOCK_OUT_NS   8'h19
`define PRDC_LOCK_CYCLES   3'h5
// Regulator ramp time
`define PRDC_CLK_MHZ       50
`define PRDC_REG_UP_US     50
`define PRDC_REG_UP_CYC    (`PRDC_REG_UP_US * `PRDC_CLK_MHZ)
// Interrupt bits
`define PRDC_IRQ_READY     0
`define PRDC_IRQ_LOCK      1
`define PRDC_IRQ_UNLOCK    2
`define PRDC_IRQ_CALDONE   3
`endif

// ===== hdl/prdc_pkg.sv
`default_nettype none
package prdc_pkg;
  // Regulator power states
  typedef enum logic [2:0] {
    PRDC_PWR_OFF   = 3'b001,
    PRDC_PWR_RAMP  = 3'b010,
    PRDC_PWR_READY = 3'b100
  } prdc_pwr_t;
  // Status output selections
  typedef enum logic [2:0] {
    PRDC_MUX_READY = 3'h0,
    PRDC_MUX_LOCK  = 3'h1,
    PRDC_MUX_CAL   = 3'h2,
    PRDC_MUX_RSSI  = 3'h3,
    PRDC_MUX_TXRX  = 3'h4
  } prdc_mux_t;
endpackage : prdc_pkg
`default_nettype wire

// ===== hdl/prdc_ref_ctrl.sv
// Functional notes
// - Oscillator runs on enable bit, off when CE low
// - Two-bit crystal bias field selects current
// - Divided clock 50:50, inverted to reference
// - Divided clock ratio even, 2 to 30
// - Divided clock defaults to divide by eight
// - Divide field zero disables divided clock
// - Reference counter divides 1 to 7
// - Reference counter defaults to one
// - Eight-bit integer divide, 23 to 255
// - Fraction adds value over two to fifteen
// - Halver select halves synthesized output
// - CE low erases registers, regulators off
// - Status mux selected by top three bits
// - Status defaults to regulator ready flag
// - Calibration flag low during calibration
// - Lock after five good cycles, lost at 25 ns
// - Direction low in transmit, high in receive
`include "prdc_params.svh"
`default_nettype none
module prdc_ref_ctrl (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        chip_enable_pin,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  input  wire logic [7:0]  phase_err_ns,
  input  wire logic        cal_busy,
  input  wire logic        rssi_ready,
  input  wire logic        tx_mode,
  output logic             osc_enable,
  output logic      [1:0]  crystal_bias_field,
  output logic             divided_ref_output,
  output logic             divided_ref_oe,
  output logic             phase_detector_tick,
  output logic      [8:0]  inst_feedback_div,
  output logic             output_halver_select,
  output logic             supply_ok_flag,
  output logic             pll_lock_flag,
  output logic             status_mux_output,
  output logic             irq
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [31:0]        synth_word;
  logic [31:0]        ref_word;
  logic [3:0]         irq_stat;
  logic [3:0]         irq_mask;
  logic [3:0]         irq_event;
  prdc_pkg::prdc_pwr_t pwr_state;
  logic [12:0]        ramp_cnt;
  logic               bus_ok;
  logic               wr_synth;
  logic               wr_ref;

  // Writes only land once the regulator is up and CE is high
  assign bus_ok   = chip_enable_pin && supply_ok_flag;
  assign wr_synth = bus_wr && bus_ok && (bus_addr == `PRDC_OFF_SYNTH);
  assign wr_ref   = bus_wr && bus_ok && (bus_addr == `PRDC_OFF_REF);

  // ----------------------------------------
  // Regulator power sequencing
  // ----------------------------------------
  // Ramp counter stands in for the analogue settling time
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwr_state <= prdc_pkg::PRDC_PWR_OFF;
      ramp_cnt  <= 13'h0000;
    end else begin
      case (pwr_state)
        prdc_pkg::PRDC_PWR_OFF: begin
          ramp_cnt <= 13'h0000;
          if (chip_enable_pin) begin
            pwr_state <= prdc_pkg::PRDC_PWR_RAMP;
          end
        end
        prdc_pkg::PRDC_PWR_RAMP: begin
          if (!chip_enable_pin) begin
            pwr_state <= prdc_pkg::PRDC_PWR_OFF;
          end else if (ramp_cnt == 13'(`PRDC_REG_UP_CYC - 1)) begin
            pwr_state <= prdc_pkg::PRDC_PWR_READY;
          end else begin
            ramp_cnt <= ramp_cnt + 13'h0001;
          end
        end
        prdc_pkg::PRDC_PWR_READY: begin
          if (!chip_enable_pin) begin
            pwr_state <= prdc_pkg::PRDC_PWR_OFF;
          end
        end
        default: begin
          pwr_state <= prdc_pkg::PRDC_PWR_OFF;
        end
      endcase
    end
  end

  // Ready flag is a flop so the status pin never glitches
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      supply_ok_flag <= 1'b0;
    end else begin
      supply_ok_flag <= chip_enable_pin && (pwr_state == prdc_pkg::PRDC_PWR_READY);
    end
  end

  // ----------------------------------------
  // Configuration words
  // ----------------------------------------
  // CE low restores defaults, as power loss would
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      synth_word <= `PRDC_SYNTH_RST;
      ref_word   <= `PRDC_REF_RST;
    end else if (!chip_enable_pin) begin
      synth_word <= `PRDC_SYNTH_RST;
      ref_word   <= `PRDC_REF_RST;
    end else begin
      if (wr_synth) begin
        synth_word <= bus_wdata;
      end
      if (wr_ref) begin
        ref_word <= bus_wdata;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
    end else if (!chip_enable_pin) begin
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
    end else begin
      if (bus_wr && bus_ok && bus_addr == `PRDC_OFF_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~bus_wdata[3:0]) | irq_event;
      end else begin
        irq_stat <= irq_stat | irq_event;
      end
      if (bus_wr && bus_ok && bus_addr == `PRDC_OFF_IRQ_MASK) begin
        irq_mask <= bus_wdata[3:0];
      end
    end
  end

  // Level interrupt from any unmasked status bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_rd) begin
      case (bus_addr)
        `PRDC_OFF_SYNTH:    bus_rdata <= synth_word;
        `PRDC_OFF_REF:      bus_rdata <= ref_word;
        `PRDC_OFF_IRQ_STAT: bus_rdata <= {28'h0000000, irq_stat};
        `PRDC_OFF_IRQ_MASK: bus_rdata <= {28'h0000000, irq_mask};
        default:            bus_rdata <= 32'h0000_0000;
      endcase
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Oscillator controls
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_enable           <= 1'b0;
      crystal_bias_field   <= 2'h0;
      output_halver_select <= 1'b0;
    end else begin
      osc_enable           <= chip_enable_pin && ref_word[`PRDC_OSC_BIT];
      crystal_bias_field   <= ref_word[`PRDC_BIAS_HI:`PRDC_BIAS_LO];
      output_halver_select <= ref_word[`PRDC_HALVER_BIT];
    end
  end

  // ----------------------------------------
  // Divided reference output
  // ----------------------------------------
  logic [3:0] ck_half;
  logic [3:0] ck_cnt;
  assign ck_half = ref_word[`PRDC_CKDIV_HI:`PRDC_CKDIV_LO];

  // Toggle every field cycles gives ratio 2*field with equal halves;
  // the pin starts high so its first edge falls against the reference
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ck_cnt             <= 4'h0;
      divided_ref_output <= 1'b1;
      divided_ref_oe     <= 1'b0;
    end else if (ck_half == 4'h0 || !chip_enable_pin) begin
      ck_cnt             <= 4'h0;
      divided_ref_output <= 1'b1;
      divided_ref_oe     <= 1'b0;
    end else begin
      divided_ref_oe <= 1'b1;
      if (ck_cnt >= ck_half - 4'h1) begin
        ck_cnt             <= 4'h0;
        divided_ref_output <= ~divided_ref_output;
      end else begin
        ck_cnt <= ck_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Reference counter
  // ----------------------------------------
  logic [2:0] r_div;
  logic [2:0] r_cnt;
  // A zero field would stall the loop, so it acts as divide by one
  assign r_div = (ref_word[`PRDC_RDIV_HI:`PRDC_RDIV_LO] == 3'h0) ? 3'h1
               : ref_word[`PRDC_RDIV_HI:`PRDC_RDIV_LO];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_cnt               <= 3'h0;
      phase_detector_tick <= 1'b0;
    end else if (r_cnt >= r_div - 3'h1) begin
      r_cnt               <= 3'h0;
      phase_detector_tick <= 1'b1;
    end else begin
      r_cnt               <= r_cnt + 3'h1;
      phase_detector_tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Feedback divider and modulator
  // ----------------------------------------
  logic [7:0]  int_div;
  logic [14:0] frac_div;
  logic [14:0] sd_acc;
  logic [15:0] next_sd_sum;
  // Values below the pulse-swallow minimum are raised to it
  assign int_div  = (synth_word[`PRDC_INT_HI:`PRDC_INT_LO] < `PRDC_INT_MIN)
                  ? `PRDC_INT_MIN : synth_word[`PRDC_INT_HI:`PRDC_INT_LO];
  assign frac_div = synth_word[`PRDC_FRAC_HI:`PRDC_FRAC_LO];
  assign next_sd_sum = {1'b0, sd_acc} + {1'b0, frac_div};

  // First-order modulator: the carry adds one to the divide
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sd_acc            <= 15'h0000;
      inst_feedback_div <= 9'h000;
    end else if (phase_detector_tick) begin
      sd_acc            <= next_sd_sum[14:0];
      inst_feedback_div <= {1'b0, int_div} + {8'h00, next_sd_sum[15]};
    end
  end

  // ----------------------------------------
  // Digital lock detect
  // ----------------------------------------
  logic [2:0] good_cnt;
  logic       lock_prev;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      good_cnt      <= 3'h0;
      pll_lock_flag <= 1'b0;
    end else if (!chip_enable_pin) begin
      good_cnt      <= 3'h0;
      pll_lock_flag <= 1'b0;
    end else if (phase_detector_tick) begin
      if (phase_err_ns >= `PRDC_LOCK_OUT_NS) begin
        pll_lock_flag <= 1'b0;
      end else if (good_cnt == `PRDC_LOCK_CYCLES - 3'h1 &&
                   phase_err_ns < `PRDC_LOCK_IN_NS) begin
        pll_lock_flag <= 1'b1;
      end
      if (phase_err_ns < `PRDC_LOCK_IN_NS) begin
        good_cnt <= (good_cnt == `PRDC_LOCK_CYCLES) ? good_cnt : good_cnt + 3'h1;
      end else begin
        good_cnt <= 3'h0;
      end
    end
  end

  // ----------------------------------------
  // Event edges for interrupts
  // ----------------------------------------
  logic ready_prev;
  logic cal_prev;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lock_prev  <= 1'b0;
      ready_prev <= 1'b0;
      cal_prev   <= 1'b0;
    end else begin
      lock_prev  <= pll_lock_flag;
      ready_prev <= supply_ok_flag;
      cal_prev   <= cal_busy;
    end
  end
  assign irq_event[`PRDC_IRQ_READY]   = supply_ok_flag && !ready_prev;
  assign irq_event[`PRDC_IRQ_LOCK]    = pll_lock_flag && !lock_prev;
  assign irq_event[`PRDC_IRQ_UNLOCK]  = !pll_lock_flag && lock_prev;
  assign irq_event[`PRDC_IRQ_CALDONE] = !cal_busy && cal_prev;

  // ----------------------------------------
  // Status multiplexer
  // ----------------------------------------
  // Unused selections read low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_mux_output <= 1'b0;
    end else begin
      case (synth_word[`PRDC_MUX_HI:`PRDC_MUX_LO])
        prdc_pkg::PRDC_MUX_READY: status_mux_output <= supply_ok_flag;
        prdc_pkg::PRDC_MUX_LOCK:  status_mux_output <= pll_lock_flag;
        prdc_pkg::PRDC_MUX_CAL:   status_mux_output <= !cal_busy;
        prdc_pkg::PRDC_MUX_RSSI:  status_mux_output <= rssi_ready;
        prdc_pkg::PRDC_MUX_TXRX:  status_mux_output <= !tx_mode;
        default:                  status_mux_output <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_osc_ce_off: assert property (
    !chip_enable_pin |=> !osc_enable)
    else $error("oscillator enabled with CE low");

  chk_erase_ce: assert property (
    !chip_enable_pin |=> ref_word == `PRDC_REF_RST && synth_word == `PRDC_SYNTH_RST)
    else $error("registers not erased by CE low");

  chk_write_gate: assert property (
    bus_wr && !supply_ok_flag |=> $stable(synth_word) && $stable(ref_word))
    else $error("write accepted before regulator ready");

  chk_clk_off: assert property (
    ck_half == 4'h0 |=> !divided_ref_oe)
    else $error("divided clock driven with zero divide");

  chk_clk_half: assert property (
    $changed(divided_ref_output) && divided_ref_oe && ck_half == 4'h2 && $stable(ck_half)
    && chip_enable_pin
    |=> $stable(divided_ref_output)
        ##1 ($changed(divided_ref_output) || $past(ck_half) != 4'h2 || !$past(chip_enable_pin)))
    else $error("divided clock halves unequal");

  chk_pd_period: assert property (
    phase_detector_tick && r_div == 3'h3
    |=> !phase_detector_tick
        ##1 (!phase_detector_tick || $past(r_div) != 3'h3)
        ##1 (phase_detector_tick || $past(r_div) != 3'h3 || $past(r_div, 2) != 3'h3))
    else $error("detector tick spacing wrong");

  chk_sd_range: assert property (
    $past(phase_detector_tick) && $stable(int_div)
    |-> inst_feedback_div == {1'b0, int_div} || inst_feedback_div == {1'b0, int_div} + 9'h001)
    else $error("instantaneous divide off range");

  chk_lock_lost: assert property (
    phase_detector_tick && phase_err_ns >= `PRDC_LOCK_OUT_NS |=> !pll_lock_flag)
    else $error("lock held after large phase error");

  chk_lock_rise: assert property (
    $rose(pll_lock_flag) |-> $past(good_cnt) >= 3'h4)
    else $error("lock set before five good cycles");

  chk_mux_ready: assert property (
    synth_word[31:29] == 3'h0 |=> status_mux_output == $past(supply_ok_flag))
    else $error("status pin not showing ready flag");

  chk_mux_dir: assert property (
    synth_word[31:29] == 3'h4 |=> status_mux_output == !$past(tx_mode))
    else $error("direction indicator wrong");

  chk_irq_level: assert property (
    |(irq_stat & irq_mask) |=> irq)
    else $error("interrupt not raised");

endmodule : prdc_ref_ctrl
`default_nettype wire

// ===== verif/pll_reference_divider_control_bench.sv
`include "prdc_params.svh"
`default_nettype none
module pll_reference_divider_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rst, chip_enable_pin, bus_wr, bus_rd;
  logic        cal_busy, rssi_ready, tx_mode, osc_enable, divided_ref_output;
  logic        divided_ref_oe, phase_detector_tick, output_halver_select;
  logic        supply_ok_flag, pll_lock_flag, status_mux_output, irq;
  logic [7:0]  bus_addr, phase_err_ns;
  logic [31:0] bus_wdata, bus_rdata, rd;
  logic [1:0]  crystal_bias_field;
  logic [8:0]  inst_feedback_div;
  int          fail_count, comparisons, seed, lo, hi, s, n;
  logic [3:0]  f;
  logic [1:0]  b;
  logic        h, o, c, q, t;
  logic [7:0]  iv;

  prdc_ref_ctrl u_prdc_ref_ctrl (.core_clk(core_clk), .rst(rst),
    .chip_enable_pin(chip_enable_pin), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .phase_err_ns(phase_err_ns),
    .cal_busy(cal_busy), .rssi_ready(rssi_ready), .tx_mode(tx_mode),
    .osc_enable(osc_enable), .crystal_bias_field(crystal_bias_field),
    .divided_ref_output(divided_ref_output), .divided_ref_oe(divided_ref_oe),
    .phase_detector_tick(phase_detector_tick), .inst_feedback_div(inst_feedback_div),
    .output_halver_select(output_halver_select), .supply_ok_flag(supply_ok_flag),
    .pll_lock_flag(pll_lock_flag), .status_mux_output(status_mux_output), .irq(irq));

  prdc_host_model u_prdc_host_model (.core_clk(core_clk), .supply_ok_flag(supply_ok_flag),
    .bus_rdata(bus_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd));

  // ------------------------------------------------------------
  // Expectations and checks
  // ------------------------------------------------------------
  function automatic logic [31:0] refw(logic hv, logic [1:0] bv, logic ov, logic [3:0] fv,
                                       logic [2:0] rv);
    refw = {13'h0000, hv, 3'h0, bv, ov, 1'b0, fv, rv, 4'h0};
  endfunction : refw

  function automatic logic [31:0] synw(logic [2:0] sv, logic [7:0] iw, logic [14:0] fr);
    synw = {sv, 2'h0, iw, fr, 4'h0};
  endfunction : synw

  // Lock is known low when the selector sweep runs
  function automatic logic exp_mux(int sv, logic cv, logic qv, logic tv);
    case (sv)
      0: exp_mux = 1'b1;
      2: exp_mux = ~cv;
      3: exp_mux = qv;
      4: exp_mux = ~tv;
      default: exp_mux = 1'b0;
    endcase
  endfunction : exp_mux

  task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val

  task automatic chk_cnt(input string what, input int e, input int g);
    comparisons++;
    if (g != e) begin
      fail_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, e, g);
    end
  endtask : chk_cnt

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc

  // Low and high lengths of the divided clock, in reference cycles
  task automatic clk_halves(output int l, output int hh);
    int m;
    m = 0;
    while (divided_ref_output !== 1'b1 && m < 100) begin cyc(1); m++; end
    while (divided_ref_output !== 1'b0 && m < 200) begin cyc(1); m++; end
    l = 0;
    while (divided_ref_output === 1'b0 && l < 100) begin cyc(1); l++; end
    hh = 0;
    while (divided_ref_output === 1'b1 && hh < 100) begin cyc(1); hh++; end
  endtask : clk_halves

  // Ticks seen in 420 cycles, a multiple of every R
  task automatic tick_count(output int k);
    k = 0;
    repeat (420) begin cyc(1); if (phase_detector_tick === 1'b1) k++; end
  endtask : tick_count

  // Sum of the instantaneous divide over eight detector cycles
  task automatic fb_sum(output int sm);
    int m;
    sm = 0;
    m = 0;
    while (m < 8) begin
      cyc(1);
      if (phase_detector_tick === 1'b1) begin sm += int'(inst_feedback_div); m++; end
    end
  endtask : fb_sum

  task automatic drive_err(input logic [7:0] v, input int k);
    repeat (k) begin @(posedge core_clk); phase_err_ns <= v; end
    cyc(1);
  endtask : drive_err

  task automatic wait_ready();
    int m;
    m = 0;
    while (supply_ok_flag !== 1'b1 && m < 3000) begin cyc(1); m++; end
  endtask : wait_ready

  task automatic results();
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Whole run is under 10000 cycles; allow six times that
  initial begin
    #(20 * 60000);
    fail_count++;
    results();
  end

  initial begin
    {rst, chip_enable_pin, cal_busy, rssi_ready, tx_mode} = 5'b11000;
    phase_err_ns = 8'h1E; // Above the loss threshold, so lock stays low until tested
    fail_count = 0;
    comparisons = 0;
    seed = 95035;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    cyc(100);
    chk_val("mux_ramp", 0, {supply_ok_flag, status_mux_output});
    u_prdc_host_model.rd32(`PRDC_OFF_REF, rd);
    chk_val("ref_reset", 32'h0000_1210, rd);
    chk_val("osc_reset", 1, osc_enable);
    wait_ready();
    cyc(2);
    chk_val("mux_ready", 1, status_mux_output);
    tick_count(n);
    chk_cnt("ticks_reset", 420, n);
    // Interrupt: ready event, mask, clear
    u_prdc_host_model.rd32(`PRDC_OFF_IRQ_STAT, rd);
    chk_val("irq_stat", 1, rd & 32'hF);
    chk_val("irq_masked", 0, irq);
    u_prdc_host_model.wr32(`PRDC_OFF_IRQ_MASK, 32'h1);
    cyc(2);
    chk_val("irq_on", 1, irq);
    u_prdc_host_model.wr32(`PRDC_OFF_IRQ_STAT, 32'h1);
    cyc(2);
    chk_val("irq_clr", 0, irq);
    // Divided clock ratio with random bias, halver and oscillator bits
    for (int i = 0; i < 4; i++) begin
      f = (i == 0) ? 4'h1 : (i == 1) ? 4'hF : (i == 2) ? 4'h2 : 4'($random(seed)) | 4'h1;
      {h, b, o} = 4'($random(seed));
      u_prdc_host_model.wr32(`PRDC_OFF_REF, refw(h, b, o, f, 3'h1));
      cyc(3);
      chk_val("bias", b, crystal_bias_field);
      chk_val("halver", h, output_halver_select);
      chk_val("osc", o, osc_enable);
      chk_val("clk_oe", 1, divided_ref_oe);
      clk_halves(lo, hi);
      chk_cnt("clk_low", f, lo);
      chk_cnt("clk_high", f, hi);
    end
    u_prdc_host_model.wr32(`PRDC_OFF_REF, refw(0, 0, 1, 0, 1));
    cyc(40);
    chk_val("clk_off", 2'b01, {divided_ref_oe, divided_ref_output});
    // Reference counter sweep, zero reads as one
    for (int r = 0; r < 8; r++) begin
      u_prdc_host_model.wr32(`PRDC_OFF_REF, refw(0, 0, 1, 4, 3'(r)));
      cyc(10);
      tick_count(n);
      chk_cnt("ticks", 420 / ((r == 0) ? 1 : r), n);
    end
    // Feedback divide: clamp, maximum and random integers, eighths of fraction
    u_prdc_host_model.wr32(`PRDC_OFF_REF, refw(0, 0, 1, 4, 2));
    for (int i = 0; i < 3; i++) begin
      iv = (i == 0) ? 8'h0A : (i == 1) ? 8'hFF : 8'h17 + 8'($random(seed) & 8'h7F);
      f = 4'($random(seed) & 32'h7);
      u_prdc_host_model.wr32(`PRDC_OFF_SYNTH, synw(0, iv, {f[2:0], 12'h000}));
      cyc(40);
      fb_sum(s);
      chk_cnt("fb_sum", 8 * ((iv < 8'h17) ? 23 : int'(iv)) + int'(f), s);
    end
    // Lock detect at one tick per cycle
    u_prdc_host_model.wr32(`PRDC_OFF_REF, refw(0, 0, 1, 4, 1));
    drive_err(8'd30, 3);
    drive_err(8'd10, 4);
    drive_err(8'd20, 3);
    chk_val("lock_four", 0, pll_lock_flag);
    drive_err(8'd14, 5);
    drive_err(8'd20, 2);
    chk_val("lock_five", 1, pll_lock_flag);
    u_prdc_host_model.wr32(`PRDC_OFF_SYNTH, synw(1, 8'h17, 15'h0000));
    cyc(2);
    chk_val("mux_lock", 1, status_mux_output);
    drive_err(8'd24, 4);
    chk_val("lock_hold", 1, pll_lock_flag);
    drive_err(8'd25, 1);
    drive_err(8'd20, 2);
    chk_val("lock_lost", 0, pll_lock_flag);
    chk_val("mux_unlock", 0, status_mux_output);
    // Calibration pulse, then status selector sweep
    @(posedge core_clk);
    cal_busy <= 1'b1;
    cyc(5);
    @(posedge core_clk);
    cal_busy <= 1'b0;
    for (int sv = 0; sv < 8; sv++) begin
      {c, q, t} = 3'($random(seed));
      @(posedge core_clk);
      {cal_busy, rssi_ready, tx_mode} <= {c, q, t};
      u_prdc_host_model.wr32(`PRDC_OFF_SYNTH, synw(3'(sv), 8'h17, 15'h0000));
      cyc(3);
      chk_val("mux", exp_mux(sv, c, q, t), status_mux_output);
    end
    u_prdc_host_model.rd32(`PRDC_OFF_IRQ_STAT, rd);
    chk_val("irq_events", 3'b111, rd[3:1]);
    u_prdc_host_model.wr32(`PRDC_OFF_IRQ_MASK, 32'hE);
    cyc(2);
    chk_val("irq_events_on", 1, irq);
    u_prdc_host_model.wr32(`PRDC_OFF_IRQ_STAT, 32'hE);
    cyc(2);
    chk_val("irq_events_clr", 0, irq);
    // Chip enable low: power off and erase
    u_prdc_host_model.wr32(`PRDC_OFF_REF, refw(1, 3, 0, 7, 5));
    @(posedge core_clk);
    chip_enable_pin <= 1'b0;
    cyc(4);
    chk_val("ce_low", 0, {osc_enable, supply_ok_flag, divided_ref_oe});
    @(posedge core_clk);
    chip_enable_pin <= 1'b1;
    u_prdc_host_model.wr32_early(`PRDC_OFF_REF, 32'h0000_0000);
    u_prdc_host_model.rd32(`PRDC_OFF_REF, rd);
    chk_val("ref_erased", 32'h0000_1210, rd);
    u_prdc_host_model.rd32(`PRDC_OFF_SYNTH, rd);
    chk_val("synth_erased", 0, rd);
    wait_ready();
    chk_val("osc_back", 1, osc_enable);
    clk_halves(lo, hi);
    chk_cnt("clk_default", 8, lo + hi);
    results();
  end
endmodule : pll_reference_divider_control_bench
`default_nettype wire

// ===== verif/prdc_host_model.sv
`default_nettype none
// ------------------------------------------------------------
// Host controller model: programs registers, watches status
// ------------------------------------------------------------
module prdc_host_model (
  input  wire logic        core_clk,
  input  wire logic        supply_ok_flag,
  input  wire logic [31:0] bus_rdata,
  output logic      [7:0]  bus_addr,
  output logic      [31:0] bus_wdata,
  output logic             bus_wr,
  output logic             bus_rd
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    bus_addr  = 8'h00;
    bus_wdata = 32'h0000_0000;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
  end

  // Write waits for the regulator, since earlier writes are lost
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    while (supply_ok_flag !== 1'b1 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge core_clk);
    bus_wr    <= 1'b0;
    bus_wdata <= ~d;  // Released lines do not keep the old value
  endtask : wr32

  // Write issued without waiting, so the regulator gate must drop it
  task automatic wr32_early(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge core_clk);
    bus_wr    <= 1'b0;
  endtask : wr32_early

  // Read data stands only in the cycle after the strobe
  task automatic rd32(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge core_clk);
    bus_rd   <= 1'b0;
    bus_addr <= ~a;
    @(negedge core_clk);
    d = bus_rdata;
  endtask : rd32
endmodule : prdc_host_model
`default_nettype wire
